// ---- common/cecs_regs.svh ----
// Constants for the CPU event counter setup block: bit positions within the
// three channel words, reset values and counter limits.
// Assumes channel words are numbered with bit 0 as the leftmost (MSB) bit.
`ifndef CECS_REGS_SVH
`define CECS_REGS_SVH

// ============================================================
// Counter control word bit positions
`define CECS_CTL_CNT_A     6
`define CECS_CTL_CNT_B     7
`define CECS_CTL_OVF_CLR   8
`define CECS_CTL_STOP_A    9
`define CECS_CTL_STOP_B    10
`define CECS_CTL_CARRY_A1  11
`define CECS_CTL_CARRY_A2  12
`define CECS_CTL_CARRY_B1  13
`define CECS_CTL_CARRY_B2  14
`define CECS_CTL_SPEC_SEL  15

// ============================================================
// Event select and qualifier word bit positions
`define CECS_EV_UP_MSB     0
`define CECS_EV_UP_LSB     4
`define CECS_EV_LO_MSB     5
`define CECS_EV_LO_LSB     9
`define CECS_EV_ALL_JOBS   11
`define CECS_EV_MON_MASK   12
`define CECS_EV_JOB_MASK   13
`define CECS_EV_DF56_MASK  14
`define CECS_EV_DF57_MASK  15

// ============================================================
// Function match word fields
`define CECS_FM_SEL_MSB    0
`define CECS_FM_SEL_LSB    7
`define CECS_FM_MASK_MSB   8
`define CECS_FM_MASK_LSB   15

// ============================================================
// Values
`define CECS_WORD_RST      16'h0000
`define CECS_CNT_MAX       16'hFFFF
`define CECS_CNT_TOP       15
`define CECS_FCODE_ZERO    8'h00
`define CECS_EVT_FMATCH    5'h12

`endif

// ---- common/cecs_pkg.sv ----
// Types shared by the event counter setup design files.
// Assumes nothing beyond the constants header.
package cecs_pkg;
    typedef logic [0:15] cecs_word_t;   // Channel word, bit 0 leftmost
    typedef logic [15:0] cecs_cnt_t;    // One 16-bit counter
    typedef logic [7:0]  cecs_fcode_t;  // Instruction function code
    typedef logic [4:0]  cecs_evcode_t; // Event select code
endpackage : cecs_pkg

// ---- verilog/cecs_fmatch.sv ----
// Masked instruction function-code comparator.
// Assumes select and mask are taken from the function match word, MSB first.
`timescale 1ns/10ps
`default_nettype none
`include "cecs_regs.svh"
module cecs_fmatch (
    input  wire logic                 clk_i,     // For assertions only
    input  wire logic                 srst_i,    // Sync reset
    input  wire cecs_pkg::cecs_fcode_t code_i,   // Issued instruction code
    input  wire logic                 valid_i,   // Instruction issued
    input  wire cecs_pkg::cecs_fcode_t sel_i,    // Select code
    input  wire cecs_pkg::cecs_fcode_t mask_i,   // Compare mask
    output logic                      match_o    // Matched event
);
    // ============================================================
    // Compare
    // Only masked positions are compared, so a zero mask matches all
    always_comb begin
        match_o = valid_i && (((code_i ^ sel_i) & mask_i) == `CECS_FCODE_ZERO);
    end

    // ============================================================
    // Checks
    property p_fm_all;
        @(posedge clk_i) disable iff (srst_i)
        (valid_i && mask_i == `CECS_FCODE_ZERO) |-> match_o;
    endproperty
    a_fm_all: assert property (p_fm_all) else $error("zero mask missed");

    property p_fm_eq;
        @(posedge clk_i) disable iff (srst_i)
        (valid_i && ((code_i & mask_i) != (sel_i & mask_i))) |-> !match_o;
    endproperty
    a_fm_eq: assert property (p_fm_eq) else $error("mismatch counted");
endmodule : cecs_fmatch
`default_nettype wire

// ---- verilog/cecs_top.sv ----
// Event counter setup and qualification for the four CPU counters.
// Assumes channel writes, events and qualifiers come from logic on the
// same clock, each event and strobe being a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
`include "cecs_regs.svh"
module cecs_top (
    input  wire logic                  CLOCK_I,        // 100 MHz
    input  wire logic                  SRST_I,         // Sync reset, high
    input  wire logic                  CTRL_WR_I,      // Control word strobe
    input  wire cecs_pkg::cecs_word_t  CTRL_DATA_I,    // Control word
    input  wire logic                  EVSEL_WR_I,     // Event word strobe
    input  wire cecs_pkg::cecs_word_t  EVSEL_DATA_I,   // Event word
    input  wire logic                  FMATCH_WR_I,    // Function word strobe
    input  wire cecs_pkg::cecs_word_t  FMATCH_DATA_I,  // Function word
    input  wire logic [31:0]           EVENT_I,        // Event pulses by code
    input  wire cecs_pkg::cecs_fcode_t FUNC_CODE_I,    // Issued function code
    input  wire logic                  FUNC_VALID_I,   // Instruction issued
    input  wire logic                  MONITOR_I,      // CPU in monitor mode
    input  wire logic                  JOB_SEL_I,      // Job selected
    input  wire logic                  DF56_HIT_I,     // Address+flag 56 hit
    input  wire logic                  DF57_HIT_I,     // Address+flag 57 hit
    input  wire logic                  READ_I,         // Read transfer pulse
    input  wire logic                  CLEAR_FAULT_I,  // Clear fault pulse
    output logic                       CPU_HALT_O,     // Stop request
    output cecs_pkg::cecs_cnt_t        DISP_A1_O,      // Snapshot A1
    output cecs_pkg::cecs_cnt_t        DISP_A2_O,      // Snapshot A2
    output cecs_pkg::cecs_cnt_t        DISP_B1_O,      // Snapshot B1
    output cecs_pkg::cecs_cnt_t        DISP_B2_O       // Snapshot B2
);
    // ============================================================
    // Declarations
    cecs_pkg::cecs_word_t ctl_reg,    ctl_next;     // Counter control
    cecs_pkg::cecs_word_t spec_a_reg, spec_a_next;  // Counter A specs
    cecs_pkg::cecs_word_t spec_b_reg, spec_b_next;  // Counter B specs
    cecs_pkg::cecs_word_t fm_reg,     fm_next;      // Function match
    cecs_pkg::cecs_cnt_t  a1_reg, a1_next;          // Pair A upper
    cecs_pkg::cecs_cnt_t  a2_reg, a2_next;          // Pair A lower
    cecs_pkg::cecs_cnt_t  b1_reg, b1_next;          // Pair B upper
    cecs_pkg::cecs_cnt_t  b2_reg, b2_next;          // Pair B lower
    cecs_pkg::cecs_cnt_t  da1_reg, da1_next;        // Display snapshots
    cecs_pkg::cecs_cnt_t  da2_reg, da2_next;
    cecs_pkg::cecs_cnt_t  db1_reg, db1_next;
    cecs_pkg::cecs_cnt_t  db2_reg, db2_next;
    logic                 halt_reg, halt_next;      // Stop latch
    logic                 fmatch;                   // Function match event
    logic [31:0]          ev_vec;                   // Events after match
    logic                 inc_a1, inc_a2;           // Qualified counts A
    logic                 inc_b1, inc_b2;           // Qualified counts B
    logic                 chain_a, chain_b;         // Pair chained
    logic                 carry_a, carry_b;         // Lower wrap into upper
    logic                 hit_a, hit_b;             // Pair incremented

    // ============================================================
    // Function code comparator
    cecs_fmatch u_fmatch (
        .clk_i   (CLOCK_I),
        .srst_i  (SRST_I),
        .code_i  (FUNC_CODE_I),
        .valid_i (FUNC_VALID_I),
        .sel_i   (fm_reg[`CECS_FM_SEL_MSB:`CECS_FM_SEL_LSB]),
        .mask_i  (fm_reg[`CECS_FM_MASK_MSB:`CECS_FM_MASK_LSB]),
        .match_o (fmatch)
    );

    // ============================================================
    // Helpers
    // Qualifier gate: every enabled mask must see its condition, except the job mask when all jobs is set
    function automatic logic qualify(input cecs_pkg::cecs_word_t spec,
                                     input logic ev);
        logic job_ok;
        job_ok = spec[`CECS_EV_ALL_JOBS] || !spec[`CECS_EV_JOB_MASK] || JOB_SEL_I;
        qualify = ev && job_ok
            && (!spec[`CECS_EV_MON_MASK] || MONITOR_I)
            && (!spec[`CECS_EV_DF56_MASK] || DF56_HIT_I)
            && (!spec[`CECS_EV_DF57_MASK] || DF57_HIT_I);
    endfunction : qualify

    // Clear on read: only the top bit when overflow clear is set
    function automatic cecs_pkg::cecs_cnt_t rd_clear(input cecs_pkg::cecs_cnt_t c,
                                                     input logic ovf);
        rd_clear = c;
        if (ovf) begin
            rd_clear[`CECS_CNT_TOP] = 1'b0;
        end else begin
            rd_clear = `CECS_WORD_RST;
        end
    endfunction : rd_clear

    // ============================================================
    // Event selection and qualification
    always_comb begin
        ev_vec = EVENT_I;
        ev_vec[`CECS_EVT_FMATCH] = fmatch;
        chain_a = ctl_reg[`CECS_CTL_CARRY_A1] || ctl_reg[`CECS_CTL_CARRY_A2];
        chain_b = ctl_reg[`CECS_CTL_CARRY_B1] || ctl_reg[`CECS_CTL_CARRY_B2];
        // Counting is gated by the start bits; setup is taken as written
        inc_a2 = ctl_reg[`CECS_CTL_CNT_A] && qualify(spec_a_reg,
                 ev_vec[spec_a_reg[`CECS_EV_LO_MSB:`CECS_EV_LO_LSB]]);
        inc_a1 = ctl_reg[`CECS_CTL_CNT_A] && !chain_a && qualify(spec_a_reg,
                 ev_vec[spec_a_reg[`CECS_EV_UP_MSB:`CECS_EV_UP_LSB]]);
        inc_b2 = ctl_reg[`CECS_CTL_CNT_B] && qualify(spec_b_reg,
                 ev_vec[spec_b_reg[`CECS_EV_LO_MSB:`CECS_EV_LO_LSB]]);
        inc_b1 = ctl_reg[`CECS_CTL_CNT_B] && !chain_b && qualify(spec_b_reg,
                 ev_vec[spec_b_reg[`CECS_EV_UP_MSB:`CECS_EV_UP_LSB]]);
        carry_a = chain_a && inc_a2 && (a2_reg == `CECS_CNT_MAX);
        carry_b = chain_b && inc_b2 && (b2_reg == `CECS_CNT_MAX);
        hit_a = inc_a1 || inc_a2;
        hit_b = inc_b1 || inc_b2;
    end

    // ============================================================
    // Channel word next values
    always_comb begin
        ctl_next    = ctl_reg;
        spec_a_next = spec_a_reg;
        spec_b_next = spec_b_reg;
        fm_next     = fm_reg;
        if (CTRL_WR_I) begin
            ctl_next = CTRL_DATA_I;
        end
        // Event word goes to the pair named by the latest control word
        if (EVSEL_WR_I) begin
            if (ctl_next[`CECS_CTL_SPEC_SEL]) begin
                spec_b_next = EVSEL_DATA_I;
            end else begin
                spec_a_next = EVSEL_DATA_I;
            end
        end
        if (FMATCH_WR_I) begin
            fm_next = FMATCH_DATA_I;
        end
    end

    // Channel word registers
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            ctl_reg    <= `CECS_WORD_RST;
            spec_a_reg <= `CECS_WORD_RST;
            spec_b_reg <= `CECS_WORD_RST;
            fm_reg     <= `CECS_WORD_RST;
        end else begin
            ctl_reg    <= ctl_next;
            spec_a_reg <= spec_a_next;
            spec_b_reg <= spec_b_next;
            fm_reg     <= fm_next;
        end
    end

    // ============================================================
    // Counter next values
    // A read drops any count in the same cycle; the snapshot stays coherent
    always_comb begin
        a1_next = a1_reg + 16'(inc_a1 || carry_a);
        a2_next = a2_reg + 16'(inc_a2);
        b1_next = b1_reg + 16'(inc_b1 || carry_b);
        b2_next = b2_reg + 16'(inc_b2);
        da1_next = da1_reg;
        da2_next = da2_reg;
        db1_next = db1_reg;
        db2_next = db2_reg;
        if (READ_I) begin
            da1_next = a1_reg;
            da2_next = a2_reg;
            db1_next = b1_reg;
            db2_next = b2_reg;
            a1_next = rd_clear(a1_reg, ctl_reg[`CECS_CTL_OVF_CLR]);
            a2_next = rd_clear(a2_reg, ctl_reg[`CECS_CTL_OVF_CLR]);
            b1_next = rd_clear(b1_reg, ctl_reg[`CECS_CTL_OVF_CLR]);
            b2_next = rd_clear(b2_reg, ctl_reg[`CECS_CTL_OVF_CLR]);
        end
    end

    // Counter registers
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            a1_reg  <= `CECS_WORD_RST;
            a2_reg  <= `CECS_WORD_RST;
            b1_reg  <= `CECS_WORD_RST;
            b2_reg  <= `CECS_WORD_RST;
            da1_reg <= `CECS_WORD_RST;
            da2_reg <= `CECS_WORD_RST;
            db1_reg <= `CECS_WORD_RST;
            db2_reg <= `CECS_WORD_RST;
        end else begin
            a1_reg  <= a1_next;
            a2_reg  <= a2_next;
            b1_reg  <= b1_next;
            b2_reg  <= b2_next;
            da1_reg <= da1_next;
            da2_reg <= da2_next;
            db1_reg <= db1_next;
            db2_reg <= db2_next;
        end
    end

    // ============================================================
    // Stop latch
    // A new stop event in the clear cycle wins, so no hit is lost
    always_comb begin
        halt_next = halt_reg;
        if (CLEAR_FAULT_I) begin
            halt_next = 1'b0;
        end
        if ((hit_a && ctl_reg[`CECS_CTL_STOP_A]) || (hit_b && ctl_reg[`CECS_CTL_STOP_B])) begin
            halt_next = 1'b1;
        end
    end

    // Stop register
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            halt_reg <= 1'b0;
        end else begin
            halt_reg <= halt_next;
        end
    end

    // ============================================================
    // Outputs
    assign CPU_HALT_O = halt_reg;
    assign DISP_A1_O  = da1_reg;
    assign DISP_A2_O  = da2_reg;
    assign DISP_B1_O  = db1_reg;
    assign DISP_B2_O  = db2_reg;

    // ============================================================
    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    sequence s_stop_hit;
        hit_a && ctl_reg[`CECS_CTL_STOP_A];
    endsequence
    sequence s_held;
        CPU_HALT_O && !CLEAR_FAULT_I;
    endsequence

    property p_stop;
        s_stop_hit |=> CPU_HALT_O;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not raised");

    property p_hold;
        s_held ##0 !hit_a |=> CPU_HALT_O;
    endproperty
    a_hold: assert property (p_hold) else $error("halt dropped early");

    property p_chain;
        (chain_a && inc_a2 && a2_reg == `CECS_CNT_MAX && !READ_I)
            |=> (a1_reg == $past(a1_reg) + 16'h0001) && (a2_reg == `CECS_WORD_RST);
    endproperty
    a_chain: assert property (p_chain) else $error("carry lost");

    property p_indep;
        (!chain_a && !inc_a1 && !READ_I) |=> $stable(a1_reg);
    endproperty
    a_indep: assert property (p_indep) else $error("upper moved alone");

    property p_mon;
        (spec_a_reg[`CECS_EV_MON_MASK] && !MONITOR_I) |-> !inc_a1 && !inc_a2;
    endproperty
    a_mon: assert property (p_mon) else $error("count out of monitor");

    property p_job;
        (spec_b_reg[`CECS_EV_JOB_MASK] && !spec_b_reg[`CECS_EV_ALL_JOBS] && !JOB_SEL_I)
            |-> !inc_b1 && !inc_b2;
    endproperty
    a_job: assert property (p_job) else $error("count out of job");

    property p_spec;
        (EVSEL_WR_I && !CTRL_WR_I && ctl_reg[`CECS_CTL_SPEC_SEL])
            |=> (spec_b_reg == $past(EVSEL_DATA_I)) && $stable(spec_a_reg);
    endproperty
    a_spec: assert property (p_spec) else $error("spec misrouted");

    property p_rdclr;
        (READ_I && !ctl_reg[`CECS_CTL_OVF_CLR])
            |=> a1_reg == `CECS_WORD_RST && b2_reg == `CECS_WORD_RST
                && DISP_A1_O == $past(a1_reg);
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read clear failed");

    property p_ovf;
        (READ_I && ctl_reg[`CECS_CTL_OVF_CLR]) |=> !a1_reg[`CECS_CNT_TOP] && !b1_reg[`CECS_CNT_TOP];
    endproperty
    a_ovf: assert property (p_ovf) else $error("top bit kept");

    property p_start;
        !ctl_reg[`CECS_CTL_CNT_B] |-> !inc_b1 && !inc_b2;
    endproperty
    a_start: assert property (p_start) else $error("count while stopped");

    // Pair B mirrors pair A for the stop latch and the chained carry
    sequence s_stop_hit_b;
        hit_b && ctl_reg[`CECS_CTL_STOP_B];
    endsequence

    property p_stop_b;
        s_stop_hit_b |=> CPU_HALT_O;
    endproperty
    a_stop_b: assert property (p_stop_b) else $error("stop B not raised");

    property p_chain_b;
        (chain_b && inc_b2 && b2_reg == `CECS_CNT_MAX && !READ_I)
            |=> (b1_reg == $past(b1_reg) + 16'h0001) && (b2_reg == `CECS_WORD_RST);
    endproperty
    a_chain_b: assert property (p_chain_b) else $error("carry B lost");
endmodule : cecs_top
`default_nettype wire

// ---- verif/cecs_mcu_model.sv ----
// Maintenance controller model: programs the three channel words, pulses
// read and clear fault. Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
module cecs_mcu_model (
    input  wire logic                  clk_i,          // Block clock
    output var  logic                  ctrl_wr_o,      // Control word strobe
    output var  cecs_pkg::cecs_word_t  ctrl_data_o,    // Control word
    output var  logic                  evsel_wr_o,     // Event word strobe
    output var  cecs_pkg::cecs_word_t  evsel_data_o,   // Event word
    output var  logic                  fmatch_wr_o,    // Function word strobe
    output var  cecs_pkg::cecs_word_t  fmatch_data_o,  // Function word
    output var  logic                  read_o,         // Read transfer pulse
    output var  logic                  clear_fault_o   // Clear fault pulse
);
    // ============================================================
    // Idle lines at time zero
    initial begin
        {ctrl_wr_o, evsel_wr_o, fmatch_wr_o, read_o, clear_fault_o} = 5'h00;
        {ctrl_data_o, evsel_data_o, fmatch_data_o} = 48'h0;
    end
    // ============================================================
    // One write per call; a following call drops this strobe, so writes
    // may run back to back
    task automatic wr(input int k, input cecs_pkg::cecs_word_t d);
        @(posedge clk_i);
        #1;
        {ctrl_wr_o, evsel_wr_o, fmatch_wr_o} = {k == 0, k == 1, k == 2};
        // Unselected words toggle so stale data is never mistaken for valid
        ctrl_data_o   = (k == 0) ? d : ~ctrl_data_o;
        evsel_data_o  = (k == 1) ? d : ~evsel_data_o;
        fmatch_data_o = (k == 2) ? d : ~fmatch_data_o;
    endtask : wr
    // Release every strobe after its taking edge
    task automatic rel();
        @(posedge clk_i);
        #1;
        {ctrl_wr_o, evsel_wr_o, fmatch_wr_o, read_o, clear_fault_o} = 5'h00;
        {ctrl_data_o, evsel_data_o, fmatch_data_o} = ~{ctrl_data_o, evsel_data_o, fmatch_data_o};
    endtask : rel
    // ============================================================
    // Program both specs with counting off, start counting last
    task automatic setup(input cecs_pkg::cecs_word_t c, ea, eb, fm,
                         output cecs_pkg::cecs_word_t cw);
        cecs_pkg::cecs_word_t b;
        cw = c;
        if (cw[8] && cw[11] && cw[12]) cw[11] = 1'b0;
        if (cw[8] && cw[13] && cw[14]) cw[13] = 1'b0;
        b = cw;
        {b[6], b[7], b[15]} = 3'h0;
        wr(0, b);
        wr(1, ea);
        b[15] = 1'b1;
        wr(0, b);
        wr(1, eb);
        wr(2, fm);
        wr(0, cw);
        rel();
    endtask : setup
    // Read transfer when rd is set, clear fault otherwise
    task automatic pulse(input logic rd);
        @(posedge clk_i);
        #1;
        {read_o, clear_fault_o} = {rd, !rd};
        rel();
    endtask : pulse
endmodule : cecs_mcu_model
`default_nettype wire

// ---- verif/cecs_top_test.sv ----
// Self-checking bench for the event counter setup block.
// Assumes the controller model drives all channel strobes and reads.
`timescale 1ns/10ps
`default_nettype none
`include "cecs_regs.svh"
module cecs_top_test;
    typedef struct {logic [15:0] a1, a2, b1, b2; logic h;} cecs_note_t;
    logic clk, srst, ctrl_wr, evsel_wr, fm_wr, rd, clrf, mon, job, f56, f57, fv, halt;
    logic rd_q = 1'b0;                           // Read taken last edge
    cecs_pkg::cecs_word_t ctrl_d, evsel_d, fm_d; // Channel words
    cecs_pkg::cecs_word_t ctl, eva, evb, fmw;    // Model of active words
    cecs_pkg::cecs_word_t c, e1, e2, f;          // Next phase words
    cecs_pkg::cecs_cnt_t d_a1, d_a2, d_b1, d_b2; // Snapshots
    cecs_pkg::cecs_fcode_t fc;                   // Issued function code
    logic [31:0] ev, r;                          // Event pulses, random
    logic [31:0] rs = 32'h0000_0032;             // Generator state
    logic [15:0] a1, a2, b1, b2;                 // Model counters
    logic h;                                     // Model halt latch
    int n_errors = 0, check_count = 0, cycles = 0;
    cecs_note_t notes[$], nt;                    // Expected read results

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    cecs_top cecs_top_i (.CLOCK_I(clk), .SRST_I(srst), .CTRL_WR_I(ctrl_wr), .CTRL_DATA_I(ctrl_d),
        .EVSEL_WR_I(evsel_wr), .EVSEL_DATA_I(evsel_d), .FMATCH_WR_I(fm_wr), .FMATCH_DATA_I(fm_d),
        .EVENT_I(ev), .FUNC_CODE_I(fc), .FUNC_VALID_I(fv), .MONITOR_I(mon), .JOB_SEL_I(job),
        .DF56_HIT_I(f56), .DF57_HIT_I(f57), .READ_I(rd), .CLEAR_FAULT_I(clrf),
        .CPU_HALT_O(halt), .DISP_A1_O(d_a1), .DISP_A2_O(d_a2), .DISP_B1_O(d_b1),
        .DISP_B2_O(d_b2));
    cecs_mcu_model cecs_mcu_model_i (.clk_i(clk), .ctrl_wr_o(ctrl_wr), .ctrl_data_o(ctrl_d),
        .evsel_wr_o(evsel_wr), .evsel_data_o(evsel_d), .fmatch_wr_o(fm_wr),
        .fmatch_data_o(fm_d), .read_o(rd), .clear_fault_o(clrf));

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    // Event codes kept to a few values so hits are frequent
    function automatic logic [4:0] pick(input logic [31:0] v);
        return v[2] ? `CECS_EVT_FMATCH : {3'b000, v[1:0]};
    endfunction : pick
    task automatic cmp(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // One counter pair over one cycle
    task automatic step(input cecs_pkg::cecs_word_t e, input logic en, ch, st, fm,
                        inout logic [15:0] up, lo);
        logic q, il, iu;
        q  = (!e[12] || mon) && (!e[13] || e[11] || job) && (!e[14] || f56) && (!e[15] || f57);
        il = en && q && ((e[5:9] == `CECS_EVT_FMATCH) ? fm : ev[e[5:9]]);
        iu = ch ? (il && lo == 16'hFFFF) : (en && q && ((e[0:4] == `CECS_EVT_FMATCH) ? fm : ev[e[0:4]]));
        lo = lo + {15'h0000, il};
        up = up + {15'h0000, iu};
        if (st && (il || iu)) h = 1'b1;
    endtask : step
    // Drive one cycle of events and qualifiers, then advance the model
    task automatic cyc(input logic [31:0] e, input logic [4:0] qv, input cecs_pkg::cecs_fcode_t fcv);
        logic fm;
        @(posedge clk);
        #1;
        ev = e;
        {mon, job, f56, f57, fv} = qv;
        fc = fcv;
        fm = fv && (((fc ^ fmw[0:7]) & fmw[8:15]) == 8'h00);
        step(eva, ctl[6], ctl[11] | ctl[12], ctl[9], fm, a1, a2);
        step(evb, ctl[7], ctl[13] | ctl[14], ctl[10], fm, b1, b2);
    endtask : cyc
    task automatic run(input int n, input logic [31:0] m, o);
        for (int k = 0; k < n; k++) begin
            r = xs();
            cyc((r & m) | o, r[8:4], r[9] ? fmw[0:7] : r[31:24]);
        end
    endtask : run
    // Quiet cycle, note the expectation, read, then clear any halt
    task automatic check_read();
        cyc(32'h0000_0000, 5'h00, 8'h00);
        notes.push_back('{a1, a2, b1, b2, h});
        cecs_mcu_model_i.pulse(1'b1);
        if (ctl[8]) {a1[15], a2[15], b1[15], b2[15]} = 4'h0;
        else {a1, a2, b1, b2} = 64'h0;
        if (h) cecs_mcu_model_i.pulse(1'b0);
        h = 1'b0;
    endtask : check_read
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // ============================================================
    // Result watcher: oldest note against the snapshot after each read
    always @(posedge clk) begin
        if (rd_q && notes.size() > 0) begin
            nt = notes.pop_front();
            cmp("a1", nt.a1, d_a1);
            cmp("a2", nt.a2, d_a2);
            cmp("b1", nt.b1, d_b1);
            cmp("b2", nt.b2, d_b2);
            cmp("halt", {15'h0000, nt.h}, {15'h0000, halt});
        end
        rd_q <= rd;
    end
    // Hang guard; the run needs about 98800 cycles, so the ceiling is tight
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            conclude();
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        ev = 32'h0000_0000;
        fc = 8'h00;
        {mon, job, f56, f57, fv} = 5'h00;
        {ctl, eva, evb, fmw, a1, a2, b1, b2} = 128'h0;
        h = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        check_read();
        // Random setups: specs, carries, stops, masks and function match
        for (int p = 0; p < 8; p++) begin
            c = xs();
            e1 = xs();
            e2 = xs();
            f = xs();
            e1[0:4] = pick(xs());
            e1[5:9] = pick(xs());
            e2[0:4] = pick(xs());
            e2[5:9] = pick(xs());
            if (p[0]) f[8:15] = 8'h00;
            cecs_mcu_model_i.setup(c, e1, e2, f, ctl);
            {eva, evb, fmw} = {e1, e2, f};
            run(40, 32'h0004_000F, 32'h0000_0000);
            check_read();
        end
        // Pair A chained, pair B split, overflow clear set
        c = 16'h0000;
        {c[6], c[7], c[8], c[12]} = 4'hF;
        e1 = 16'h0000;
        e1[0:4] = 5'h01;
        e1[5:9] = 5'h01;
        e1[11] = 1'b1;
        cecs_mcu_model_i.setup(c, e1, e1, 16'h0000, ctl);
        {eva, evb, fmw} = {e1, e1, 16'h0000};
        run(32768, 32'h0000_0000, 32'h0000_0002);
        check_read();
        run(65536, 32'h0000_0000, 32'h0000_0002);
        check_read();
        conclude();
    end
endmodule : cecs_top_test
`default_nettype wire
